/* verif/seq_link_props.sv */
// Concurrent checks on the sequencer link.
// Assumes one instance beside the link in the bench top.
`timescale 1ns/1ps
module seq_link_props
  import power_seq_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  // Link signals
  input wire seq_state_t  state,
  input wire logic [7:0]  clk_stat,
  input wire logic [7:0]  flag_clr,
  input wire logic        irq_n,
  input wire logic        host_reset_n,
  input wire logic [3:0]  err_count,
  input wire logic        mon_busy,
  input wire logic        spread_on,
  input wire logic [11:0] sync_freq_khz
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  AST_SEC_FLAG: assert property ($rose(clk_stat[4]) |-> state == ST_SAFE ##1 !irq_n)
    else $error("second flag without SAFE or irq");
  AST_BST_FLAG: assert property ($rose(clk_stat[6]) |-> state == ST_SAFE ##1 !irq_n)
    else $error("boost flag without SAFE or irq");
  AST_SEC_ERR: assert property ($rose(clk_stat[4]) && !$rose(clk_stat[6]) && $past(err_count) != 4'hf
    |-> err_count == $past(err_count) + 4'h1) else $error("count not raised by second fault");
  AST_BST_ERR: assert property ($rose(clk_stat[6]) && !$rose(clk_stat[4]) && $past(err_count) != 4'hf
    |-> err_count == $past(err_count) + 4'h1) else $error("count not raised by boost fault");
  AST_FLAG_HOLD: assert property ($fell(clk_stat[4]) || $fell(clk_stat[6])
    |-> $past(flag_clr[4]) || $past(flag_clr[6])) else $error("flag dropped without clear");
  AST_SAFE_EXIT: assert property ($past(state) == ST_SAFE && state != ST_SAFE |-> state == ST_RESET)
    else $error("SAFE left other than to RESET");
  AST_RST_LOW: assert property (state inside {ST_OFF, ST_RESET} && $past(state) == state |-> !host_reset_n)
    else $error("host reset high in OFF or RESET");
  AST_SPREAD_ON: assert property ($rose(spread_on) |-> $past(state) == ST_DIAG)
    else $error("spread enabled outside DIAG");
  AST_SPREAD_KEEP: assert property ($past(state) inside {ST_DIAG, ST_ACTIVE, ST_SAFE} && state == ST_RESET
    |-> $stable(spread_on)) else $error("spread changed entering RESET");
  AST_MON_SAFE: assert property ($rose(mon_busy) |-> $past(state) == ST_SAFE)
    else $error("monitor test outside SAFE");
  AST_SYNC_STEP: assert property ($changed(sync_freq_khz) |-> (sync_freq_khz > $past(sync_freq_khz) ?
    sync_freq_khz - $past(sync_freq_khz) : $past(sync_freq_khz) - sync_freq_khz) <= 12'h064)
    else $error("sync step above limit");
endmodule

/* verif/test_switch_clock_fault_recovery.sv */
// Bench of the fail-safe sequencer joined to its AHB-Lite host controller.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/1ps
`include "seq_defines.svh"
module test_switch_clock_fault_recovery;
  import power_seq_pkg::*;
  logic        core_clk, rstn, hsel, hwrite, hreadyout, hresp, strap_ext_mod, second_rst_src, boost_rst_src;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  err_threshold;
  logic [11:0] sw_freq_khz;
  logic        power_up, osc_good, second_clk_fault, boost_clk_fault, sync_good, pll_good, second_uv;
  logic        second_restart_ok, boost_uv, boost_restart_ok, selftest_done, selftest_pass, mon_test_done;
  logic        mon_test_pass, second_rail_en, boost_rail_en, rail_discharge_en, selftest_start;
  logic        mon_test_start, drive_enable_irq_n, host_reset_out_n;
  int          mismatches, n_tests, cycles, t;

  seq_link_if seq_link_if_inst ();
  fail_safe_seq #(.RESET_TO_CYC(20), .HOP_CYC(4)) fail_safe_seq_inst (
    .core_clk, .rstn, .link(seq_link_if_inst), .strap_ext_mod, .second_rst_src, .boost_rst_src,
    .err_threshold, .power_up, .osc_good, .second_clk_fault, .boost_clk_fault, .sync_good, .pll_good,
    .second_uv, .second_restart_ok, .boost_uv, .boost_restart_ok, .selftest_done, .selftest_pass,
    .mon_test_done, .mon_test_pass, .second_rail_en, .boost_rail_en, .rail_discharge_en,
    .selftest_start, .mon_test_start, .sw_freq_khz, .drive_enable_irq_n, .host_reset_out_n);
  seq_host_ctrl #(.STEP_CYC(8)) seq_host_ctrl_inst (
    .core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .link(seq_link_if_inst));
  seq_link_props seq_link_props_inst (
    .core_clk, .rstn, .state(seq_link_if_inst.state), .clk_stat(seq_link_if_inst.clk_stat),
    .flag_clr(seq_link_if_inst.flag_clr), .irq_n(seq_link_if_inst.irq_n),
    .host_reset_n(seq_link_if_inst.host_reset_n), .err_count(seq_link_if_inst.err_count),
    .mon_busy(seq_link_if_inst.mon_busy), .spread_on(seq_link_if_inst.spread_on),
    .sync_freq_khz(seq_link_if_inst.sync_freq_khz));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] stat(seq_state_t s, logic hr, logic iq, logic fl, logic [3:0] e);
    return {20'h0_0000, e, 1'b0, fl, 1'b0, iq, hr, s};
  endfunction

  function automatic logic [31:0] clamp(int v);
    return (v < `SYNC_LO_KHZ) ? `SYNC_LO_KHZ : (v > `SYNC_HI_KHZ) ? `SYNC_HI_KHZ : v;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // Single AHB-Lite word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk);
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge core_clk iff hreadyout);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge core_clk iff hreadyout);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), e, q & m);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic selftest(input logic p);
    @(posedge core_clk iff selftest_start);
    selftest_done <= 1'b1;
    selftest_pass <= p;
    power_up <= 1'b0;
    @(posedge core_clk);
    selftest_done <= 1'b0;
    wt(2);
  endtask

  initial begin
    {hwrite, htrans, haddr, hwdata, power_up, second_rst_src, boost_rst_src, second_clk_fault} = '0;
    {boost_clk_fault, sync_good, second_uv, boost_uv, selftest_done, selftest_pass, mon_test_done} = '0;
    {strap_ext_mod, mon_test_pass, mismatches, n_tests, cycles} = '0;
    {hsel, osc_good, pll_good, second_restart_ok, boost_restart_ok} = '1;
    hsize = 3'b010;
    err_threshold = 4'hf;
    rstn = 1'b0;
    t = $urandom(32'h0d44_a796);
    wt(4);
    rstn <= 1'b1;
    rd(`OFS_STATUS, 32'hffff_ffff, stat(ST_OFF, 1'b0, 1'b1, 1'b0, 4'h0));
    rd(`OFS_CFG, 32'hffff_ffff, 32'h0);
    rd(8'h14, 32'hffff_ffff, 32'h0);
    $display("test reset done");
    power_up <= 1'b1;
    wt(6);
    chk("second_rail_en", 32'h0, {31'h0, second_rail_en});
    chk("boost_rail_en", 32'h1, {31'h0, boost_rail_en});
    chk("selftest_start", 32'h0, {31'h0, selftest_start});
    sync_good <= 1'b1;
    selftest(1'b1);
    rd(`OFS_STATUS, 32'hffff_ffff, stat(ST_DIAG, 1'b1, 1'b1, 1'b0, 4'h0));
    chk("host_reset_out_n", 32'h1, {31'h0, host_reset_out_n});
    wr(`OFS_CFG, 32'h0000_0006);
    rd(`OFS_CFG, 32'hffff_ffff, 32'h0000_0006);
    repeat (40) begin
      @(posedge core_clk);
      chk("sw_freq_khz", 32'h1, {31'h0, sw_freq_khz >= `SPREAD_MIN_KHZ && sw_freq_khz <= `SPREAD_MAX_KHZ});
    end
    strap_ext_mod <= 1'b1;
    repeat (3) begin
      t = 32'h0000_0640 + $urandom_range(32'h0000_03e8);
      wr(`OFS_SYNC, 32'(t));
      wt(80);
      rd(`OFS_SYNC, 32'h0000_0fff, clamp(t));
      chk("sw_freq_khz", clamp(t), {20'h0_0000, sw_freq_khz});
    end
    $display("test power-up and spread done");
    osc_good <= 1'b0;
    second_clk_fault <= 1'b1;
    wt(3);
    {osc_good, second_clk_fault} <= 2'b10;
    rd(`OFS_CLK_STAT, 32'hffff_ffff, 32'h0);
    second_clk_fault <= 1'b1;
    wt(3);
    second_clk_fault <= 1'b0;
    second_uv <= 1'b1;
    wt(5);
    chk("second_rail_en", 32'h0, {31'h0, second_rail_en});
    chk("rail_discharge_en", 32'h0, {31'h0, rail_discharge_en});
    chk("drive_enable_irq_n", 32'h0, {31'h0, drive_enable_irq_n});
    rd(`OFS_STATUS, 32'hffff_ffff, stat(ST_SAFE, 1'b1, 1'b0, 1'b0, 4'h1));
    rd(`OFS_CLK_STAT, 32'hffff_ffff, 32'h0000_0010);
    wr(`OFS_CMD, 32'h0000_0001);
    wt(2);
    chk("second_rail_en", 32'h1, {31'h0, second_rail_en});
    second_uv <= 1'b0;
    wr(`OFS_CMD, 32'h0000_0004);
    @(posedge core_clk iff mon_test_start);
    mon_test_done <= 1'b1;
    @(posedge core_clk);
    mon_test_done <= 1'b0;
    rd(`OFS_STATUS, 32'hffff_ffff, stat(ST_SAFE, 1'b1, 1'b0, 1'b1, 4'h1));
    wr(`OFS_CFG, 32'h0000_0007);
    boost_clk_fault <= 1'b1;
    wt(3);
    boost_clk_fault <= 1'b0;
    rd(`OFS_CLK_STAT, 32'hffff_ffff, 32'h0000_0010);
    wr(`OFS_CFG, 32'h0000_0006);
    wr(`OFS_CLK_STAT, 32'h0000_0010);
    rd(`OFS_CLK_STAT, 32'hffff_ffff, 32'h0);
    $display("test second rail fault done");
    boost_rst_src <= 1'b1;
    boost_clk_fault <= 1'b1;
    wt(3);
    chk("boost_rail_en", 32'h0, {31'h0, boost_rail_en});
    rd(`OFS_CLK_STAT, 32'hffff_ffff, 32'h0000_0040);
    boost_restart_ok <= 1'b0;
    boost_uv <= 1'b1;
    rd(`OFS_STATUS, 32'h0000_0007, ST_RESET);
    rd(`OFS_CFG, 32'h0000_0002, 32'h0000_0002);
    boost_restart_ok <= 1'b1;
    wt(3);
    chk("boost_rail_en", 32'h0, {31'h0, boost_rail_en});
    boost_clk_fault <= 1'b0;
    wt(3);
    chk("boost_rail_en", 32'h1, {31'h0, boost_rail_en});
    wt(30);
    rd(`OFS_STATUS, 32'h0000_0007, ST_OFF);
    rd(`OFS_CFG, 32'h0000_0002, 32'h0);
    $display("test boost fault done");
    {boost_uv, boost_rst_src, power_up} <= 3'b001;
    selftest(1'b0);
    rd(`OFS_STATUS, 32'h0000_0007, ST_SAFE);
    {err_threshold, second_rst_src, second_uv} <= 6'b0001_11;
    wt(3);
    second_uv <= 1'b0;
    selftest(1'b0);
    rd(`OFS_STATUS, 32'h0000_0007, ST_OFF);
    $display("test self-test failure done");
    report_and_stop();
  end
endmodule

/* verilog/fail_safe_seq.sv */
// Fail-safe sequencer for switching-clock faults on the second buck and boost rails.
// Assumes monitor, self-test and rail levels arrive synchronous to core_clk.
// Behaviour
// - Second rail clock fault: flag, disable, SAFE
// - Second rail reset source: UV enters RESET
// - Restart second rail when discharged, clocks good
// - Self-test after restart, no reset condition
// - Self-test fail: SAFE, OFF at threshold
// - Second rail ramp time-out goes OFF
// - Not reset source: stay SAFE, host enables
// - Boost clock fault: flag, disable, SAFE
// - Boost reset source: UV enters RESET
// - Restart boost when discharged, clock good
// - Self-test after boost restart
// - Boost ramp time-out goes OFF
// - Boost not reset source: host enables
// - Host may disable monitoring in SAFE
// - Host-commanded monitor test in SAFE
// - External or internal spread, strap selected
// - Host spaces sync steps, limits size
// - VCO until reset high, then sync
// - Internal spread band 1790 to 2398 kHz
// - Spread stays within 17 percent
// - Spread off at power-up, enable in DIAGNOSTIC
// - Spread cleared by OFF, kept in RESET
// - Second rail flag at bit 4
// - Boost flag at bit 6
`timescale 1ns/1ps
`include "seq_defines.svh"
module fail_safe_seq
  import power_seq_pkg::*;
#(
  parameter int RESET_TO_CYC = `RESET_TIMEOUT_CYC,
  parameter int HOP_CYC      = `SPREAD_HOP_CYC
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Host link
  seq_link_if.device      link,
  // Straps and configuration
  input  wire logic       strap_ext_mod,
  input  wire logic       second_rst_src,
  input  wire logic       boost_rst_src,
  input  wire logic [3:0] err_threshold,
  input  wire logic       power_up,
  // Clock monitors
  input  wire logic       osc_good,
  input  wire logic       second_clk_fault,
  input  wire logic       boost_clk_fault,
  input  wire logic       sync_good,
  input  wire logic       pll_good,
  // Rail levels
  input  wire logic       second_uv,
  input  wire logic       second_restart_ok,
  input  wire logic       boost_uv,
  input  wire logic       boost_restart_ok,
  // Self-tests
  input  wire logic       selftest_done,
  input  wire logic       selftest_pass,
  input  wire logic       mon_test_done,
  input  wire logic       mon_test_pass,
  // Rail and test controls
  output logic            second_rail_en,
  output logic            boost_rail_en,
  output logic            rail_discharge_en,
  output logic            selftest_start,
  output logic            mon_test_start,
  output logic [11:0]     sw_freq_khz,
  output logic            drive_enable_irq_n,
  output logic            host_reset_out_n
);
  seq_state_t  st_q;
  seq_state_t  st_d;
  logic [7:0]  flag_q;
  logic [3:0]  err_q;
  logic        sec_raw_q;
  logic        bst_raw_q;
  logic        st_run_q;
  logic        mon_busy_q;
  logic        mon_fail_q;
  logic        spread_q;
  logic        irq_q;
  logic        host_reset_out_n_q;
  logic [9:0]  lfsr_q;
  logic [6:0]  hop_q;
  logic [11:0] freq_q;
  logic        sec_to;
  logic        bst_to;
  logic        sec_en;
  logic        bst_en;

  // Operating states and monitor gating
  wire in_off    = (st_q == ST_OFF);
  wire in_reset  = (st_q == ST_RESET);
  wire in_safe   = (st_q == ST_SAFE);
  wire in_diag   = (st_q == ST_DIAG);
  wire operating = ~in_off;
  wire mon_on    = ~link.mon_dis;

  wire sec_raw = second_clk_fault & osc_good & mon_on & operating;
  wire sec_ev  = sec_raw & ~sec_raw_q;
  wire bst_raw = boost_clk_fault & osc_good & mon_on & operating;
  wire bst_ev  = bst_raw & ~bst_raw_q;
  wire any_ev  = sec_ev | bst_ev;

  wire rst_cond = (second_rst_src & second_uv) | (boost_rst_src & boost_uv);
  // self-test once rails up and no reset condition
  wire st_go   = in_reset & sec_en & bst_en & ~second_uv & ~boost_uv & ~rst_cond & ~st_run_q;
  wire st_fail = st_run_q & selftest_done & ~selftest_pass;
  wire st_ok   = st_run_q & selftest_done & selftest_pass;
  wire err_hit = ({1'b0, err_q} + 5'h01) >= {1'b0, err_threshold};
  wire err_inc = (any_ev | st_fail) & (err_q != 4'hF);

  // host enables only when not a reset source
  wire sec_host_en = link.second_en_set & in_safe & ~second_rst_src;
  wire bst_host_en = link.boost_en_set & in_safe & ~boost_rst_src;

  wire [7:0] flag_set = ({7'h00, sec_ev} << `SECOND_FLAG_BIT) | ({7'h00, bst_ev} << `BOOST_FLAG_BIT);
  wire [7:0] flag_d   = (flag_q & ~link.flag_clr) | flag_set;

  // second rail clocks: sync, PLL and own monitor
  wire sec_clk_good = sync_good & pll_good & ~second_clk_fault;
  wire bst_clk_good = ~boost_clk_fault;

  wire [9:0]  fold      = (lfsr_q >= `SPREAD_SPAN) ? lfsr_q - `SPREAD_FOLD : lfsr_q;
  wire [11:0] rand_freq = `SPREAD_MIN_KHZ + {2'h0, fold};
  // free-running VCO until reset high and sync present
  wire        use_sync  = link.sync_drive & host_reset_out_n_q & sync_good;
  // strap selects external or internal spread
  wire [11:0] ext_freq  = use_sync ? link.sync_freq_khz : `SPREAD_CENTER_KHZ;
  wire [11:0] int_freq  = spread_q ? rand_freq : `SPREAD_CENTER_KHZ;
  wire [11:0] freq_sel  = strap_ext_mod ? ext_freq : int_freq;
  wire [11:0] freq_lim  = (freq_sel < `SYNC_LO_KHZ) ? `SYNC_LO_KHZ :
                          (freq_sel > `SYNC_HI_KHZ) ? `SYNC_HI_KHZ : freq_sel;
  wire        hop       = (hop_q == 7'(HOP_CYC - 1));

  // Next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_OFF: begin
        if (power_up) begin
          st_d = ST_RESET;
        end
      end
      ST_RESET: begin
        if (sec_to | bst_to) begin
          st_d = ST_OFF;
        end else if (any_ev) begin
          st_d = ST_SAFE;
        end else if (st_fail) begin
          st_d = err_hit ? ST_OFF : ST_SAFE;
        end else if (st_ok) begin
          st_d = ST_DIAG;
        end
      end
      ST_DIAG, ST_ACTIVE: begin
        if (any_ev) begin
          st_d = ST_SAFE;
        end else if (rst_cond) begin
          st_d = ST_RESET;
        end else if (in_diag & link.go_active) begin
          st_d = ST_ACTIVE;
        end
      end
      ST_SAFE: begin
        if (rst_cond) begin
          st_d = ST_RESET;
        end
      end
      default: begin
        st_d = ST_OFF;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_q      <= ST_OFF;
      flag_q    <= `CLK_STAT_RST;
      err_q     <= `ERR_CNT_RST;
      sec_raw_q <= 1'b0;
      bst_raw_q <= 1'b0;
      st_run_q  <= 1'b0;
      irq_q     <= 1'b0;
      host_reset_out_n_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      flag_q    <= flag_d;
      sec_raw_q <= sec_raw;
      bst_raw_q <= bst_raw;
      err_q     <= err_inc ? err_q + 4'h1 : err_q;
      st_run_q  <= (st_run_q & ~selftest_done & in_reset) | st_go;
      // interrupt pin low while flags stand
      irq_q     <= |flag_d;
      host_reset_out_n_q    <= (st_d == ST_DIAG) | (st_d == ST_ACTIVE) | (st_d == ST_SAFE);
    end
  end

  // Monitor test and spread enable
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mon_busy_q <= 1'b0;
      mon_fail_q <= 1'b0;
      spread_q   <= 1'b0;
    end else begin
      if (mon_busy_q & mon_test_done) begin
        mon_busy_q <= 1'b0;
        mon_fail_q <= ~mon_test_pass;
      end else if (link.mon_test_req & in_safe & ~mon_busy_q) begin
        mon_busy_q <= 1'b1;
        mon_fail_q <= 1'b0;
      end
      // spread written in DIAGNOSTIC, cleared in OFF
      if (in_off) begin
        spread_q <= 1'b0;
      end else if (link.spread_wr & in_diag) begin
        spread_q <= link.spread_val;
      end
    end
  end

  // Switching frequency
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lfsr_q <= `LFSR_RST;
      hop_q  <= 7'h00;
      freq_q <= `SPREAD_CENTER_KHZ;
    end else begin
      hop_q  <= hop ? 7'h00 : hop_q + 7'h01;
      lfsr_q <= hop ? {lfsr_q[8:0], lfsr_q[9] ^ lfsr_q[6]} : lfsr_q;
      freq_q <= freq_lim;
    end
  end

  rail_recovery #(.TO_CYC(RESET_TO_CYC)) u_second (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .in_off      (in_off),
    .in_reset    (in_reset),
    .fault_ev    (sec_ev),
    .host_en     (sec_host_en),
    .restart_ok  (second_restart_ok),
    .clocks_good (sec_clk_good),
    .uv          (second_uv),
    .en_q        (sec_en),
    .timeout     (sec_to)
  );

  rail_recovery #(.TO_CYC(RESET_TO_CYC)) u_boost (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .in_off      (in_off),
    .in_reset    (in_reset),
    .fault_ev    (bst_ev),
    .host_en     (bst_host_en),
    .restart_ok  (boost_restart_ok),
    .clocks_good (bst_clk_good),
    .uv          (boost_uv),
    .en_q        (bst_en),
    .timeout     (bst_to)
  );

  // Outputs
  assign second_rail_en     = sec_en;
  assign boost_rail_en      = bst_en;
  assign rail_discharge_en  = 1'b0;
  assign selftest_start     = st_run_q;
  assign mon_test_start     = mon_busy_q;
  assign sw_freq_khz        = freq_q;
  assign drive_enable_irq_n = ~irq_q;
  assign host_reset_out_n   = host_reset_out_n_q;
  assign link.state         = st_q;
  assign link.clk_stat      = flag_q;
  assign link.irq_n         = ~irq_q;
  assign link.host_reset_n  = host_reset_out_n_q;
  assign link.err_count     = err_q;
  assign link.mon_busy      = mon_busy_q;
  assign link.mon_fail      = mon_fail_q;
  assign link.spread_on     = spread_q;
endmodule

/* verilog/power_seq_pkg.sv */
// Types shared by the sequencer and its host controller.
// Assumes nothing of its surroundings.
package power_seq_pkg;
  typedef enum logic [2:0] {
    ST_OFF    = 3'h0,
    ST_RESET  = 3'h1,
    ST_DIAG   = 3'h2,
    ST_ACTIVE = 3'h3,
    ST_SAFE   = 3'h4
  } seq_state_t;
endpackage

/* verilog/rail_recovery.sv */
// Enable and ramp time-out of one switched rail.
// Assumes the sequencer supplies its state and qualified fault event.
`timescale 1ns/1ps
`include "seq_defines.svh"
module rail_recovery
  import power_seq_pkg::*;
#(
  parameter int TO_CYC = `RESET_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Sequencer view
  input  wire logic in_off,
  input  wire logic in_reset,
  input  wire logic fault_ev,
  input  wire logic host_en,
  // Rail view
  input  wire logic restart_ok,
  input  wire logic clocks_good,
  input  wire logic uv,
  output logic      en_q,
  output logic      timeout
);
  localparam int CW = $clog2(TO_CYC + 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  wire restart = in_reset & ~en_q & restart_ok & clocks_good;
  wire ramping = in_reset & en_q & uv;
  assign cnt_d = ramping ? cnt_q + 1'b1 : '0;
  assign timeout = ramping & (cnt_q == CW'(TO_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      en_q  <= 1'b0;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      if (in_off | fault_ev) begin
        en_q <= 1'b0;
      end else if (restart | host_en) begin
        en_q <= 1'b1;
      end
    end
  end
endmodule

/* verilog/seq_defines.svh */
// Offsets, field positions, reset values and timing counts of the sequencer pair.
// Assumes a 100 MHz core clock; included by the sequencer, rail and host controller files.
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH

// Clock rate
`define CLK_MHZ 100

// Reset-state ramp time-out, in microseconds, and its cycle count
`define RESET_TIMEOUT_US 1000
`define RESET_TIMEOUT_CYC (`RESET_TIMEOUT_US * `CLK_MHZ)

// Least spacing of sync frequency steps, and largest step
`define SYNC_STEP_US 50
`define SYNC_STEP_CYC (`SYNC_STEP_US * `CLK_MHZ)
`define SYNC_STEP_MAX_KHZ 12'h0064

// Internal spread band: 1790, 2398 and 2100 kHz
`define SPREAD_MIN_KHZ 12'h06FE
`define SPREAD_MAX_KHZ 12'h095E
`define SPREAD_CENTER_KHZ 12'h0834
`define SPREAD_SPAN 10'h0261
`define SPREAD_FOLD 10'h0200
`define SPREAD_HOP_US 1
`define SPREAD_HOP_CYC (`SPREAD_HOP_US * `CLK_MHZ)
`define LFSR_RST 10'h001

// Spread limits in percent of nominal
`define SPREAD_WARN_PCT 17
`define SPREAD_ERR_PCT 20
`define SYNC_LO_KHZ 12'(32'h0834 * (100 - `SPREAD_WARN_PCT) / 100)
`define SYNC_HI_KHZ 12'(32'h0834 * (100 + `SPREAD_WARN_PCT) / 100)

// Clock status field positions
`define SECOND_FLAG_BIT 4
`define BOOST_FLAG_BIT 6
`define CLK_STAT_RST 8'h00

// Host register offsets
`define OFS_CMD 8'h00
`define OFS_STATUS 8'h04
`define OFS_CFG 8'h08
`define OFS_CLK_STAT 8'h0C
`define OFS_SYNC 8'h10

// Command and configuration bits
`define CMD_SECOND_EN_BIT 0
`define CMD_BOOST_EN_BIT 1
`define CMD_MON_TEST_BIT 2
`define CMD_GO_ACTIVE_BIT 3
`define CFG_MON_DIS_BIT 0
`define CFG_SPREAD_BIT 1
`define CFG_SYNC_BIT 2
`define CFG_RST 3'h0
`define ERR_CNT_RST 4'h0

`endif

/* verilog/seq_host_ctrl.sv */
// Host controller: AHB-Lite registers that drive the sequencer link.
// Assumes a single AHB-Lite master with word transfers on the core clock.
`timescale 1ns/1ps
`include "seq_defines.svh"
module seq_host_ctrl
  import power_seq_pkg::*;
#(
  parameter int STEP_CYC = `SYNC_STEP_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Sequencer link
  seq_link_if.host         link
);
  localparam int SW = $clog2(STEP_CYC + 1);
  logic        wr_q;
  logic [7:0]  wa_q;
  logic [31:0] rd_q;
  logic [2:0]  cfg_q;
  logic [11:0] tgt_q;
  logic [11:0] cur_q;
  logic [SW-1:0] step_q;

  // Address phase decode
  wire        take   = hsel & htrans[1] & hready;
  wire [7:0]  ra     = haddr[7:0];
  wire [31:0] status = {20'h0_0000, link.err_count, 1'b0, link.mon_fail, link.mon_busy,
                        link.irq_n, link.host_reset_n, link.state};
  wire [31:0] cfg_rd = {29'h0000_0000, cfg_q[2], link.spread_on, cfg_q[0]};
  wire [31:0] rd_sel = (ra == `OFS_STATUS)   ? status :
                       (ra == `OFS_CFG)      ? cfg_rd :
                       (ra == `OFS_CLK_STAT) ? {24'h00_0000, link.clk_stat} :
                       (ra == `OFS_SYNC)     ? {20'h0_0000, cur_q} : 32'h0000_0000;

  // Data phase write strobes
  wire w_cmd  = wr_q & (wa_q == `OFS_CMD);
  wire w_cfg  = wr_q & (wa_q == `OFS_CFG);
  wire w_clr  = wr_q & (wa_q == `OFS_CLK_STAT);
  wire w_sync = wr_q & (wa_q == `OFS_SYNC);
  wire in_safe = (link.state == ST_SAFE);

  wire [11:0] tgt_lim = (hwdata[11:0] < `SYNC_LO_KHZ) ? `SYNC_LO_KHZ :
                        (hwdata[11:0] > `SYNC_HI_KHZ) ? `SYNC_HI_KHZ : hwdata[11:0];
  wire        step_due = (step_q == SW'(STEP_CYC - 1));
  wire [11:0] diff     = (tgt_q > cur_q) ? tgt_q - cur_q : cur_q - tgt_q;
  wire [11:0] step     = (diff > `SYNC_STEP_MAX_KHZ) ? `SYNC_STEP_MAX_KHZ : diff;
  wire [11:0] cur_d    = (tgt_q > cur_q) ? cur_q + step : cur_q - step;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      rd_q <= 32'h0000_0000;
    end else begin
      wr_q <= take & hwrite;
      wa_q <= take ? ra : wa_q;
      rd_q <= (take & ~hwrite) ? rd_sel : rd_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cfg_q  <= `CFG_RST;
      tgt_q  <= `SPREAD_CENTER_KHZ;
      cur_q  <= `SPREAD_CENTER_KHZ;
      step_q <= '0;
    end else begin
      // monitoring disable taken in SAFE only
      if (w_cfg & in_safe) begin
        cfg_q[`CFG_MON_DIS_BIT] <= hwdata[`CFG_MON_DIS_BIT];
      end
      if (w_cfg) begin
        cfg_q[`CFG_SYNC_BIT]   <= hwdata[`CFG_SYNC_BIT];
        cfg_q[`CFG_SPREAD_BIT] <= hwdata[`CFG_SPREAD_BIT];
      end
      if (w_sync) begin
        tgt_q <= tgt_lim;
      end
      step_q <= step_due ? '0 : step_q + 1'b1;
      cur_q  <= step_due ? cur_d : cur_q;
    end
  end

  // AHB answers: zero wait, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rd_q;

  // Link orders
  assign link.second_en_set = w_cmd & hwdata[`CMD_SECOND_EN_BIT];
  assign link.boost_en_set  = w_cmd & hwdata[`CMD_BOOST_EN_BIT];
  assign link.mon_test_req  = w_cmd & hwdata[`CMD_MON_TEST_BIT];
  assign link.go_active     = w_cmd & hwdata[`CMD_GO_ACTIVE_BIT];
  assign link.flag_clr      = w_clr ? hwdata[7:0] : 8'h00;
  assign link.spread_wr     = w_cfg;
  assign link.spread_val    = hwdata[`CFG_SPREAD_BIT];
  assign link.mon_dis       = cfg_q[`CFG_MON_DIS_BIT];
  // sync driven only after reset output high
  assign link.sync_drive    = cfg_q[`CFG_SYNC_BIT] & link.host_reset_n;
  assign link.sync_freq_khz = cur_q;
endmodule

/* verilog/seq_link_if.sv */
// Link between the fail-safe sequencer and its host controller.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface seq_link_if;
  import power_seq_pkg::*;
  seq_state_t  state;
  logic [7:0]  clk_stat;
  logic [7:0]  flag_clr;
  logic        irq_n;
  logic        host_reset_n;
  logic [3:0]  err_count;
  logic        second_en_set;
  logic        boost_en_set;
  logic        mon_dis;
  logic        mon_test_req;
  logic        mon_busy;
  logic        mon_fail;
  logic        go_active;
  logic        spread_wr;
  logic        spread_val;
  logic        spread_on;
  logic        sync_drive;
  logic [11:0] sync_freq_khz;

  modport device (
    output state, clk_stat, irq_n, host_reset_n, err_count, mon_busy, mon_fail, spread_on,
    input  flag_clr, second_en_set, boost_en_set, mon_dis, mon_test_req, go_active,
    input  spread_wr, spread_val, sync_drive, sync_freq_khz
  );
  modport host (
    input  state, clk_stat, irq_n, host_reset_n, err_count, mon_busy, mon_fail, spread_on,
    output flag_clr, second_en_set, boost_en_set, mon_dis, mon_test_req, go_active,
    output spread_wr, spread_val, sync_drive, sync_freq_khz
  );
endinterface
